/* File: fsr_defs.vh */
// fsr_defs.vh: constants for the floppy status reporting block.
// assumes a 50 MHz core clock and a sequencer that drives the event inputs.
//
// Contract
// - digital input bit 7 is the inverse of the cable disk-change level.
// - at-style mode ignores the polarity-invert strap for the disk-change bit.
// - at-style mode forces disk-change inactive when drive inputs are forced off.
// - at-style mode leaves digital input bits 6 to 0 undriven on reads.
// - ps2-style mode reads bits 6 to 3 as ones.
// - bits 2 to 1 show data rate; soft reset keeps it, hard reset gives 250k.
// - bit 0 low at 500k or 1M, high at 250k or 300k.
// - result bytes come from data register only in result phase.
// - status zero bits 7 to 6 hold the termination code.
// - status zero bit 5 set when seek or recalibrate completes.
// - status zero bit 4 set when recalibrate ends without track zero.
// - status zero bit 2 head, bits 1 to 0 drive, captured at execution end.
// - status one bit 7 set on last end-of-track byte without terminal count.
// - status one bit 5 flags crc error; status two bit 5 tells data field.
// - status one bit 4 set when host misses the service deadline.
// - status one bit 2 set on sector missing, read-id failure or start missing.
// - status one bit 1 set on write or format with write-protect active.
// - status one bit 0 set on missing address mark; status two bit 0 tells data mark.
// - data-field crc error also sets status one crc bit.
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH

// low address bits of the two i/o ports
`define FSR_PORT_DATA 3'h5
`define FSR_PORT_DIN 3'h7

// data rate codes
`define FSR_RATE_500K 2'h0
`define FSR_RATE_300K 2'h1
`define FSR_RATE_250K 2'h2
`define FSR_RATE_1M 2'h3
`define FSR_RATE_RESET 2'h2

// result byte index
`define FSR_IDX_ST0 2'h0
`define FSR_IDX_ST1 2'h1
`define FSR_IDX_ST2 2'h2

// digital input fields
`define FSR_DIN_CHG 7
`define FSR_DIN_ONES 4'hf
`define FSR_DIN_LOW_Z 7'h7f

// service deadlines in us and clock rate in mhz
`define FSR_CLK_MHZ 50
`define FSR_T_SLOW_US 62
`define FSR_T_250_US 30
`define FSR_T_500_US 14
`define FSR_T_1M_US 6
`define FSR_CYC_SLOW (`FSR_T_SLOW_US * `FSR_CLK_MHZ)
`define FSR_CYC_250 (`FSR_T_250_US * `FSR_CLK_MHZ)
`define FSR_CYC_500 (`FSR_T_500_US * `FSR_CLK_MHZ)
`define FSR_CYC_1M (`FSR_T_1M_US * `FSR_CLK_MHZ)
`define FSR_CNT_W 12

`endif

/* File: fsr_sticky.v */
// fsr_sticky.v: a bank of sticky status flags.
// assumes set and clear are synchronous one-cycle pulses.
`timescale 1ns/10ps
module fsr_sticky #(
  parameter W = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire clr,
  input wire [W-1:0] set,
  // flags
  output wire [W-1:0] q
);
  reg [W-1:0] flag;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge clk)
      begin
        // set beats a clear landing in the same cycle
        if (rst)
          flag[i] <= 1'b0;
        else if (set[i])
          flag[i] <= 1'b1;
        else if (clr)
          flag[i] <= 1'b0;
      end
    end
  endgenerate
  assign q = flag;
endmodule

/* File: fsr_deadline.v */
// fsr_deadline.v: host service deadline watch for execution transfers.
// assumes req is a level held until ack pulses.
`include "fsr_defs.vh"
`timescale 1ns/10ps
module fsr_deadline #(
  parameter CW = `FSR_CNT_W
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // rate and request
  input wire [1:0] rate,
  input wire req,
  input wire ack,
  // result
  output reg expire
);
  reg [CW-1:0] cnt;
  reg fired;
  reg [CW-1:0] limit;
  // deadlines held at counter width so the limit mux never truncates
  localparam [CW-1:0] LIM_SLOW = `FSR_CYC_SLOW;
  localparam [CW-1:0] LIM_250 = `FSR_CYC_250;
  localparam [CW-1:0] LIM_500 = `FSR_CYC_500;
  localparam [CW-1:0] LIM_1M = `FSR_CYC_1M;

  always @*
  begin
    case (rate)
      `FSR_RATE_500K: limit = LIM_500;
      `FSR_RATE_1M: limit = LIM_1M;
      `FSR_RATE_250K: limit = LIM_250;
      // 300k uses the 250k figure, slightly generous for that rate
      `FSR_RATE_300K: limit = LIM_250;
      default: limit = LIM_SLOW;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= {CW{1'b0}};
      fired <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      if (!req || ack)
      begin
        cnt <= {CW{1'b0}};
        fired <= 1'b0;
      end
      else if (!fired)
      begin
        if (cnt >= limit - 1'b1)
        begin
          // one pulse per missed request
          expire <= 1'b1;
          fired <= 1'b1;
        end
        else
          cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

/* File: fsr_status.v */
// fsr_status.v: digital input register and result status bytes.
// assumes the command sequencer pulses the event inputs and steps
// result_index while result_phase is high; rst is the hardware reset.
`include "fsr_defs.vh"
`timescale 1ns/10ps
module fsr_status (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire soft_rst,
  // host i/o port
  input wire [2:0] io_addr,
  input wire io_rd,
  output reg [7:0] rd_data,
  output reg [7:0] rd_data_oe_n,
  // rate select write
  input wire rate_wr,
  input wire [1:0] rate_wdata,
  // mode and straps
  input wire at_mode,
  input wire invert_strap,
  input wire drive_inputs_off,
  // drive cable
  input wire disk_change_flag,
  input wire track_zero,
  input wire write_protect,
  input wire transfer_end_count,
  // command sequencing
  input wire cmd_start,
  input wire result_phase,
  input wire [1:0] result_index,
  input wire exec_end,
  input wire [1:0] term_code,
  input wire head_sel,
  input wire [1:0] drive_sel,
  // execution events
  input wire seek_done,
  input wire recal_active,
  input wire recal_done,
  input wire eot_last_byte,
  input wire crc_addr_err,
  input wire crc_data_err,
  input wire sector_missing,
  input wire read_id_fail,
  input wire track_start_missing,
  input wire write_cmd_issue,
  input wire addr_mark_missing,
  input wire data_mark_missing,
  // host service handshake
  input wire service_req,
  input wire service_ack,
  // status to the rest of the controller
  output reg [1:0] data_rate,
  output reg overrun_flag
);
  reg [1:0] end_code;
  reg end_head;
  reg [1:0] end_drive;
  reg track0_hit;
  reg chg_sync;
  reg [7:0] next_rd_data;
  reg [7:0] next_oe_n;
  reg [7:0] din_val;
  wire [7:0] st0;
  wire [7:0] st1;
  wire [7:0] st2;
  wire [7:0] st1_flags;
  wire [7:0] st2_flags;
  wire [7:0] st1_set;
  wire [7:0] st2_set;
  wire [7:0] st0_set;
  wire [7:0] st0_flags;
  wire overrun_pulse;
  wire chg_active;
  wire rd_din;
  wire rd_dat;

  // data rate: only a hardware reset restores it
  always @(posedge clk)
  begin
    if (rst)
      data_rate <= `FSR_RATE_RESET;
    else if (rate_wr)
      data_rate <= rate_wdata;
  end

  // disk change level; the strap has no say in either mode
  assign chg_active = ~disk_change_flag;

  always @(posedge clk)
  begin
    if (rst)
      chg_sync <= 1'b0;
    else if (at_mode && drive_inputs_off)
      chg_sync <= 1'b0;
    else
      chg_sync <= chg_active;
  end

  // end-of-execution capture
  always @(posedge clk)
  begin
    if (rst || soft_rst)
    begin
      end_code <= 2'h0;
      end_head <= 1'b0;
      end_drive <= 2'h0;
    end
    else if (exec_end)
    begin
      end_code <= term_code;
      end_head <= head_sel;
      end_drive <= drive_sel;
    end
  end

  // track zero seen during the current recalibrate
  always @(posedge clk)
  begin
    if (rst || cmd_start)
      track0_hit <= 1'b0;
    else if (recal_active && track_zero)
      track0_hit <= 1'b1;
  end

  // status zero sticky bits
  assign st0_set[7:6] = 2'h0;
  assign st0_set[5] = seek_done | recal_done;
  assign st0_set[4] = recal_done & ~track0_hit & ~track_zero;
  assign st0_set[3:0] = 4'h0;

  // status one sticky bits
  assign st1_set[7] = eot_last_byte & ~transfer_end_count;
  assign st1_set[6] = 1'b0;
  assign st1_set[5] = crc_addr_err | crc_data_err;
  assign st1_set[4] = overrun_pulse;
  assign st1_set[3] = 1'b0;
  assign st1_set[2] = sector_missing | read_id_fail | track_start_missing;
  assign st1_set[1] = write_cmd_issue & write_protect;
  assign st1_set[0] = addr_mark_missing | data_mark_missing;

  // status two: only the bits that qualify status one are kept here
  assign st2_set[7:6] = 2'h0;
  assign st2_set[5] = crc_data_err;
  assign st2_set[4:1] = 4'h0;
  assign st2_set[0] = data_mark_missing;

  fsr_sticky #(
    .W(8)
  ) u_st0 (
    .clk(clk),
    .rst(rst),
    .clr(cmd_start | soft_rst),
    .set(st0_set),
    .q(st0_flags)
  );

  fsr_sticky #(
    .W(8)
  ) u_st1 (
    .clk(clk),
    .rst(rst),
    .clr(cmd_start | soft_rst),
    .set(st1_set),
    .q(st1_flags)
  );

  fsr_sticky #(
    .W(8)
  ) u_st2 (
    .clk(clk),
    .rst(rst),
    .clr(cmd_start | soft_rst),
    .set(st2_set),
    .q(st2_flags)
  );

  fsr_deadline #(
    .CW(`FSR_CNT_W)
  ) u_deadline (
    .clk(clk),
    .rst(rst),
    .rate(data_rate),
    .req(service_req),
    .ack(service_ack),
    .expire(overrun_pulse)
  );

  always @(posedge clk)
  begin
    if (rst)
      overrun_flag <= 1'b0;
    else
      overrun_flag <= st1_flags[4];
  end

  // status zero byte: termination, seek and equipment flags, captured unit
  assign st0[7:6] = end_code;
  assign st0[5] = st0_flags[5];
  assign st0[4] = st0_flags[4];
  assign st0[3] = 1'b0;
  assign st0[2] = end_head;
  assign st0[1:0] = end_drive;
  // status one byte; bits 6 and 3 are unused and read low
  assign st1[7] = st1_flags[7];
  assign st1[6] = 1'b0;
  assign st1[5] = st1_flags[5];
  assign st1[4] = st1_flags[4];
  assign st1[3] = 1'b0;
  assign st1[2] = st1_flags[2];
  assign st1[1] = st1_flags[1];
  assign st1[0] = st1_flags[0];
  // status two keeps only the bits that qualify status one
  assign st2[7:6] = 2'h0;
  assign st2[5] = st2_flags[5];
  assign st2[4:1] = 4'h0;
  assign st2[0] = st2_flags[0];

  // digital input value in the compatibility mode that does drive the low bits
  always @*
  begin
    din_val = 8'h00;
    din_val[`FSR_DIN_CHG] = chg_sync;
    din_val[6:3] = `FSR_DIN_ONES;
    din_val[2:1] = data_rate;
    // high density indicator is low for the two fast rates
    din_val[0] = ~((data_rate == `FSR_RATE_500K) || (data_rate == `FSR_RATE_1M));
  end

  assign rd_din = io_rd && (io_addr == `FSR_PORT_DIN);
  assign rd_dat = io_rd && (io_addr == `FSR_PORT_DATA) && result_phase;

  always @*
  begin
    next_rd_data = 8'h00;
    next_oe_n = 8'hff;
    if (rd_din)
    begin
      next_rd_data = din_val;
      next_oe_n = 8'h00;
      if (at_mode)
      begin
        // low bits belong to the hard disk side, so they float
        next_rd_data[6:0] = 7'h00;
        next_oe_n[6:0] = `FSR_DIN_LOW_Z;
      end
    end
    else if (rd_dat)
    begin
      // outside the result phase this port stays quiet here
      next_oe_n = 8'h00;
      case (result_index)
        `FSR_IDX_ST0: next_rd_data = st0;
        `FSR_IDX_ST1: next_rd_data = st1;
        `FSR_IDX_ST2: next_rd_data = st2;
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
      rd_data_oe_n <= 8'hff;
    end
    else
    begin
      rd_data <= next_rd_data;
      rd_data_oe_n <= next_oe_n;
    end
  end
endmodule

/* File: fsr_host.sv */
// fsr_host.sv: host model reading the status i/o ports and answering service requests.
// assumes the controller clock; requests change just after rising edges.
`timescale 1ns/10ps
module fsr_host (
  // clock
  input wire clk,
  // i/o port
  output reg [2:0] io_addr = 3'h0,
  output reg io_rd = 1'b0,
  input wire [7:0] rd_data,
  input wire [7:0] rd_data_oe_n,
  // service handshake
  input wire service_req,
  input wire [11:0] lat,
  output reg service_ack = 1'b0
);
  integer n = 0;
  // data-port reads are issued by the caller inside the result phase, and once outside it to check the port stays quiet
  task rd(input [2:0] a, output [7:0] d, output [7:0] oe);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    #1;
    d = rd_data;
    oe = rd_data_oe_n;
  endtask
  // a large lat misses the deadline on purpose
  always @(posedge clk)
  begin
    n <= (service_req && !service_ack) ? n + 1 : 0;
    service_ack <= service_req && !service_ack && n == lat;
  end
endmodule

/* File: fsr_status_asserts.sv */
// fsr_status_asserts.sv: port checks for the status block.
// assumes it is bound into fsr_status and sees its ports by name.
`include "fsr_defs.vh"
`timescale 1ns/10ps
module fsr_status_asserts (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched ports
  input wire soft_rst,
  input wire [2:0] io_addr,
  input wire io_rd,
  input wire rate_wr,
  input wire at_mode,
  input wire drive_inputs_off,
  input wire disk_change_flag,
  input wire result_phase,
  input wire service_req,
  input wire service_ack,
  input wire [7:0] rd_data,
  input wire [7:0] rd_data_oe_n,
  input wire [1:0] data_rate,
  input wire overrun_flag
);
  reg [12:0] wait_n;
  wire dir_rd = io_rd && io_addr == 3'h7;
  wire [12:0] lim = data_rate == 2'h0 ? `FSR_CYC_500 : (data_rate == 2'h3 ? `FSR_CYC_1M : `FSR_CYC_250);
  // a few cycles of slack cover the flag pipeline
  always @(posedge clk)
    wait_n <= (rst || !service_req || service_ack) ? 13'h0 : wait_n + 13'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_dir_ones: assert property (dir_rd && !at_mode |=> rd_data_oe_n == 8'h00 && rd_data[6:3] == 4'hf)
    else $error("fixed ones missing");
  a_dir_float: assert property (dir_rd && at_mode |=> rd_data_oe_n == 8'h7f && rd_data[6:0] == 7'h00)
    else $error("low bits driven");
  a_chg_inverse: assert property (dir_rd && !drive_inputs_off && !$past(drive_inputs_off)
    |=> rd_data[7] == !$past(disk_change_flag, 2))
    else $error("change bit wrong");
  a_chg_forced: assert property (dir_rd && at_mode && drive_inputs_off && $past(drive_inputs_off)
    |=> !rd_data[7])
    else $error("change bit not forced");
  a_rate_bits: assert property (dir_rd && !at_mode
    |=> rd_data[2:1] == $past(data_rate) && rd_data[0] == ^$past(data_rate))
    else $error("rate bits wrong");
  a_rate_hard: assert property (disable iff (1'b0) rst |=> data_rate == 2'h2)
    else $error("reset rate wrong");
  a_rate_soft: assert property (soft_rst && !rate_wr |=> data_rate == $past(data_rate))
    else $error("soft reset moved rate");
  a_data_refuse: assert property (io_rd && io_addr == 3'h5 && !result_phase
    |=> rd_data_oe_n == 8'hff && rd_data == 8'h00)
    else $error("data port answered");
  a_overrun_due: assert property (wait_n == lim + 13'h4 |-> overrun_flag)
    else $error("overrun late");
endmodule
bind fsr_status fsr_status_asserts chk (.*);

/* File: fsr_status_tb_top.sv */
// fsr_status_tb_top.sv: self-checking bench for the floppy status block.
// assumes fsr_host on the i/o port and the bound port checker.
`include "fsr_defs.vh"
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("unexpected %0t got %h want %h", $time, g, e); end end
module fsr_status_tb_top;
  localparam [71:0] ST1 = 72'h80_20_20_04_04_04_02_01_01;
  localparam [71:0] ST2 = 72'h00_00_20_00_00_00_00_00_01;
  reg clk = 0, rst = 1, soft_rst = 0, rate_wr = 0, at_mode = 0, invert_strap = 0, drive_inputs_off = 0, hd;
  reg disk_change_flag = 0, track_zero = 0, write_protect = 0, transfer_end_count = 0, cmd_start = 0;
  reg result_phase = 0, exec_end = 0, head_sel = 0, recal_active = 0, service_req = 0;
  reg [1:0] rate_wdata = 0, result_index = 0, term_code = 0, drive_sel = 0, dv;
  reg [10:0] ev = 0;
  reg [11:0] lat = 0;
  reg [7:0] d, oe;
  integer miscompares = 0, comparisons = 0, cyc = 0, m_rate = 2, k, w;
  wire [2:0] io_addr;
  wire [7:0] rd_data, rd_data_oe_n;
  wire [1:0] data_rate;
  wire io_rd, service_ack, overrun_flag, seek_done, recal_done, eot_last_byte, crc_addr_err, crc_data_err;
  wire sector_missing, read_id_fail, track_start_missing, write_cmd_issue, addr_mark_missing, data_mark_missing;
  assign {eot_last_byte, crc_addr_err, crc_data_err, sector_missing, read_id_fail, track_start_missing,
    write_cmd_issue, addr_mark_missing, data_mark_missing, seek_done, recal_done} = ev;
  fsr_status uut (.*);
  fsr_host host (.*);
  initial
  begin
    forever #10 clk = ~clk;
  end
  task tally_and_finish;
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task tk;
    @(posedge clk);
  endtask
  task look(input [2:0] a, input [7:0] e, input [7:0] eo);
    host.rd(a, d, oe);
    `CHK(d, e)
    `CHK(oe, eo)
  endtask
  // m_rate is the model's copy of the selected rate
  function [7:0] din_exp();
    din_exp = at_mode ? {~drive_inputs_off & ~disk_change_flag, 7'h00}
      : {~disk_change_flag, 4'hf, m_rate[1:0], m_rate == 1 || m_rate == 2};
  endfunction
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 10000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial
  begin
    void'($urandom(91));
    repeat (20) tk;
    rst <= 0;
    tk;
    look(3'h7, din_exp(), 8'h00);
    for (k = 0; k < 8; k++)
    begin
      tk;
      {at_mode, rate_wr, rate_wdata} <= {k[2], !k[2], k[1:0]};
      {drive_inputs_off, disk_change_flag, invert_strap} <= {k[2] & k[0], 2'($urandom)};
      tk;
      {rate_wr, soft_rst} <= 2'h1;
      m_rate = k[2] ? m_rate : k;
      tk;
      soft_rst <= 0;
      look(3'h7, din_exp(), {1'b0, {7{k[2]}}});
    end
    tk;
    {at_mode, drive_inputs_off} <= 2'h0;
    look(3'h5, 8'h00, 8'hff);
    // head and drive change after capture, so a live copy would fail
    for (k = 0; k < 4; k++)
    begin
      tk;
      {result_phase, cmd_start, recal_active} <= {2'h1, k > 1};
      tk;
      {cmd_start, track_zero, ev[1:0], head_sel, drive_sel} <= {1'b0, k == 3, k == 1, k > 1, 3'($urandom)};
      tk;
      {ev, recal_active, exec_end, term_code} <= {13'h1, 2'(k)};
      {hd, dv} = {head_sel, drive_sel};
      tk;
      {exec_end, result_phase, result_index, head_sel, drive_sel} <= {4'h4, ~hd, ~dv};
      look(3'h5, {2'(k), k != 0, k == 2, 1'b0, hd, dv}, 8'h00);
    end
    for (k = 0; k < 11; k++)
    begin
      tk;
      {result_phase, cmd_start, write_protect, transfer_end_count} <= {2'h1, k == 6, k == 9};
      tk;
      cmd_start <= 0;
      ev <= 11'h1 << (k < 9 ? 10 - k : (k == 9 ? 10 : 4));
      tk;
      {ev, result_phase, result_index} <= {12'h1, 2'h1};
      look(3'h5, k < 9 ? ST1[8 * (8 - k) +: 8] : 8'h00, 8'h00);
      tk;
      result_index <= 2;
      look(3'h5, k < 9 ? ST2[8 * (8 - k) +: 8] : 8'h00, 8'h00);
    end
    for (k = 0; k < 2; k++)
    begin
      tk;
      {result_phase, cmd_start, rate_wr, rate_wdata, lat} <= {5'hc, k ? 12'd800 : 12'd600};
      tk;
      {cmd_start, rate_wr, service_req} <= 3'h1;
      for (w = 0; w < 2000 && service_ack !== 1'b1; w++)
        @(negedge clk);
      tk;
      {service_req, result_phase, result_index} <= 4'h5;
      look(3'h5, {3'h0, k[0], 4'h0}, 8'h00);
      `CHK(overrun_flag, k[0])
    end
    tally_and_finish;
  end
endmodule
